// ---- shared/card_bus_regs.svh ----
// constants of the card bus port: host register map, fields, timing
// assumes byte addresses on the host register bus, one word per register
`ifndef CARD_BUS_REGS_SVH
`define CARD_BUS_REGS_SVH

`define OFS_HOST_ADDR 6'h00
`define OFS_WDATA 6'h04
`define OFS_CMD 6'h08
`define OFS_RDATA 6'h0c
`define OFS_STATUS 6'h10
`define OFS_CARD_CTRL 6'h14
`define OFS_TIMING 6'h18
`define OFS_IRQ_STATUS 6'h1c
`define OFS_IRQ_MASK 6'h20

`define CMD_GO 0
`define CMD_WRITE 1
`define CMD_BYTE 2

`define ST_BUSY 0
`define ST_WIDTH8 1
`define ST_PRESENT 2
`define ST_IRQ_LINE 3

`define CC_WAIT_DIS 0
`define CC_RESET 1

`define TM_IO_LSB 0
`define TM_ATTR_LSB 8
`define TM_MEM_LSB 16
`define TM_RESET 24'h080808

`define EV_DONE 0
`define EV_CARD_IRQ 1
`define EV_STSCHG 2
`define EV_ERROR 3

`define RGN_MASK 32'hffff_f800
`define IO_BASE 32'h3000_0000
`define ATTR_BASE 32'h3800_0000
`define MEM_BASE 32'h3c00_0000

`define CE_WORD 2'b10
`define CE_BYTE 2'b01
`define CE_NONE 2'b11

`define CARD_WORDS 1024
`define WAIT_W 4

`endif

// ---- shared/card_bus_pkg.sv ----
// types shared by both ends of the card bus port
package card_bus_pkg;
  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_setup = 4'b0010,
    st_strobe = 4'b0100,
    st_hold = 4'b1000
  } host_state_t;

  typedef enum logic [1:0] {
    rgn_io = 2'h0,
    rgn_attr = 2'h1,
    rgn_mem = 2'h2,
    rgn_none = 2'h3
  } region_t;
endpackage

// ---- shared/card_bus_if.sv ----
// card bus wires between the host controller and the 16-bit card
// assumes a pulled-up data bus: the level is high when nobody drives it
`timescale 1ns/10ps
interface card_bus_if;
  logic [10:0] addr;
  logic [1:0] ce_n;
  logic reg_n;
  logic mem_rd_n;
  logic mem_wr_n;
  logic io_rd_n;
  logic io_wr_n;
  logic card_reset;
  logic [15:0] host_d_out;
  logic host_d_oe;
  logic [15:0] card_d_out;
  logic card_d_oe;
  logic [15:0] d;
  logic io_is16_n;
  logic wait_n;
  logic irq_n;
  logic stschg_n;
  logic [1:0] cd_n;

  assign d = host_d_oe ? host_d_out : (card_d_oe ? card_d_out : 16'hffff);

  modport host (
    output addr, ce_n, reg_n, mem_rd_n, mem_wr_n, io_rd_n, io_wr_n, card_reset,
    output host_d_out, host_d_oe,
    input d, io_is16_n, wait_n, irq_n, stschg_n, cd_n
  );
  modport card (
    input addr, ce_n, reg_n, mem_rd_n, mem_wr_n, io_rd_n, io_wr_n, card_reset,
    input d,
    output card_d_out, card_d_oe, io_is16_n, wait_n, irq_n, stschg_n, cd_n
  );
endinterface

// ---- rtl/card_host.sv ----
// host end of the card bus: Avalon-MM register slave driving card cycles
// assumes card bus inputs are asynchronous to clock; one clock domain
//
// Summary of operation
// - eleven address bits, three 2048-location regions
// - 0x3000_0000 window makes I/O cycles
// - 0x3800_0000 window makes attribute cycles
// - 0x3c00_0000 window makes memory cycles
// - region select low attribute, high memory
// - I/O width flag sizes the read data
// - wait low stretches cycle until high
// - control bit disables the wait input
// - word access: upper enable 1, lower 0
// - card word address starts at A1
// - card holds both detect lines low
// - card interrupt request reaches software
// - status change interrupts; output resets card
// - sample card needs no byte lanes
// - separate timing field per region
`timescale 1ns/10ps
`include "card_bus_regs.svh"
module card_host
  import card_bus_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  card_bus_if.host bus
);

  ////////////////////////////////////////////////////////////////////////
  // input conditioning: three flops, a change counts when two agree
  localparam int SW = 22;
  logic [SW-1:0] raw, s1, s2, s3, filt;
  assign raw = {bus.cd_n, bus.io_is16_n, bus.wait_n, bus.irq_n, bus.stschg_n, bus.d};

  always_ff @(posedge clock) begin
    if (srst) begin
      s1 <= {SW{1'b1}};
      s2 <= {SW{1'b1}};
      s3 <= {SW{1'b1}};
      filt <= {SW{1'b1}};
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      filt <= (s2 & s3) | (filt & (s2 ^ s3));
    end
  end

  logic [1:0] cd_f;
  logic is16_n_f, wait_f, irq_f, stschg_f;
  logic [15:0] d_f;
  assign {cd_f, is16_n_f, wait_f, irq_f, stschg_f, d_f} = filt;

  ////////////////////////////////////////////////////////////////////////
  // registers and cycle engine
  host_state_t state, next_state;
  region_t rgn, next_rgn;
  logic [31:0] host_addr, next_host_addr;
  logic [15:0] wdata, next_wdata, rdata, next_rdata;
  logic cmd_write, next_cmd_write, cmd_byte, next_cmd_byte;
  logic width8, next_width8;
  logic [1:0] card_ctrl, next_card_ctrl;
  logic [23:0] timing, next_timing;
  logic [3:0] ev, next_ev, mask, next_mask;
  logic [7:0] cnt, next_cnt;
  logic stschg_q, next_stschg_q;
  logic [31:0] next_readdata;
  logic next_waitrequest, next_irq;
  logic [10:0] next_addr;
  logic [1:0] next_ce_n;
  logic next_reg_n, next_mem_rd_n, next_mem_wr_n, next_io_rd_n, next_io_wr_n;
  logic [15:0] next_d_out;
  logic next_d_oe;
  logic wr_hit, rd_hit, present, go;
  region_t dec;
  logic [7:0] t_sel;
  logic [3:0] ev_set;

  always_comb begin
    present = (cd_f == 2'b00);
    wr_hit = write && !waitrequest;
    rd_hit = read && !waitrequest;
    if ((host_addr & `RGN_MASK) == `IO_BASE) dec = rgn_io;
    else if ((host_addr & `RGN_MASK) == `ATTR_BASE) dec = rgn_attr;
    else if ((host_addr & `RGN_MASK) == `MEM_BASE) dec = rgn_mem;
    else dec = rgn_none;
    case (rgn)
      rgn_io: t_sel = timing[`TM_IO_LSB +: 8];
      rgn_attr: t_sel = timing[`TM_ATTR_LSB +: 8];
      default: t_sel = timing[`TM_MEM_LSB +: 8];
    endcase
    go = wr_hit && address == `OFS_CMD && writedata[`CMD_GO];

    next_state = state;
    next_rgn = rgn;
    next_host_addr = host_addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_cmd_write = cmd_write;
    next_cmd_byte = cmd_byte;
    next_width8 = width8;
    next_card_ctrl = card_ctrl;
    next_timing = timing;
    next_mask = mask;
    next_cnt = cnt;
    next_stschg_q = stschg_f;
    next_addr = bus.addr;
    next_ce_n = bus.ce_n;
    next_reg_n = bus.reg_n;
    next_mem_rd_n = bus.mem_rd_n;
    next_mem_wr_n = bus.mem_wr_n;
    next_io_rd_n = bus.io_rd_n;
    next_io_wr_n = bus.io_wr_n;
    next_d_out = bus.host_d_out;
    next_d_oe = bus.host_d_oe;
    ev_set = 4'h0;
    ev_set[`EV_CARD_IRQ] = !irq_f;
    ev_set[`EV_STSCHG] = stschg_q && !stschg_f;

    // ordinary register writes; command regs frozen while a cycle runs
    if (wr_hit) begin
      case (address)
        `OFS_HOST_ADDR: if (state == st_idle) next_host_addr = writedata;
        `OFS_WDATA: if (state == st_idle) next_wdata = writedata[15:0];
        `OFS_CARD_CTRL: next_card_ctrl = writedata[1:0];
        `OFS_TIMING: next_timing = writedata[23:0];
        `OFS_IRQ_MASK: next_mask = writedata[3:0];
        default: ;
      endcase
    end

    case (state)
      st_idle: begin
        if (go) begin
          if (dec == rgn_none || !present) begin
            ev_set[`EV_ERROR] = 1'b1;
          end else begin
            next_state = st_setup;
            next_rgn = dec;
            next_cmd_write = writedata[`CMD_WRITE];
            next_cmd_byte = writedata[`CMD_BYTE];
            next_addr = host_addr[10:0];
            next_ce_n = writedata[`CMD_BYTE] ? `CE_BYTE : `CE_WORD;
            next_reg_n = (dec != rgn_attr);
            next_d_out = wdata;
            next_d_oe = writedata[`CMD_WRITE];
          end
        end
      end
      st_setup: begin
        next_state = st_strobe;
        next_cnt = t_sel;
        next_mem_rd_n = !(rgn != rgn_io && !cmd_write);
        next_mem_wr_n = !(rgn != rgn_io && cmd_write);
        next_io_rd_n = !(rgn == rgn_io && !cmd_write);
        next_io_wr_n = !(rgn == rgn_io && cmd_write);
      end
      st_strobe: begin
        if (cnt != 8'h00) begin
          next_cnt = cnt - 8'h01;
        end else if (wait_f || card_ctrl[`CC_WAIT_DIS]) begin
          next_state = st_hold;
          next_mem_rd_n = 1'b1;
          next_mem_wr_n = 1'b1;
          next_io_rd_n = 1'b1;
          next_io_wr_n = 1'b1;
          // the card reports its width only in I/O space
          next_width8 = (rgn == rgn_io) ? is16_n_f : cmd_byte;
          if (!cmd_write) next_rdata = next_width8 ? {8'h00, d_f[7:0]} : d_f;
        end
      end
      st_hold: begin
        // enables, region select and data outlast the strobe by one cycle
        next_state = st_idle;
        next_ce_n = `CE_NONE;
        next_reg_n = 1'b1;
        next_d_oe = 1'b0;
        ev_set[`EV_DONE] = 1'b1;
      end
      default: next_state = st_idle;
    endcase

    // set beats a write-one clear in the same cycle
    next_ev = ev | ev_set;
    if (wr_hit && address == `OFS_IRQ_STATUS) next_ev = (ev & ~writedata[3:0]) | ev_set;
    next_irq = |(next_ev & next_mask);

    next_waitrequest = !((read || write) && waitrequest);
    next_readdata = readdata;
    if (read && waitrequest) begin
      case (address)
        `OFS_HOST_ADDR: next_readdata = host_addr;
        `OFS_WDATA: next_readdata = {16'h0000, wdata};
        `OFS_RDATA: next_readdata = {16'h0000, rdata};
        `OFS_STATUS: next_readdata = {28'h0, !irq_f, present, width8, state != st_idle};
        `OFS_CARD_CTRL: next_readdata = {30'h0, card_ctrl};
        `OFS_TIMING: next_readdata = {8'h00, timing};
        `OFS_IRQ_STATUS: next_readdata = {28'h0, ev};
        `OFS_IRQ_MASK: next_readdata = {28'h0, mask};
        default: next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= st_idle;
      rgn <= rgn_none;
      host_addr <= 32'h0000_0000;
      wdata <= 16'h0000;
      rdata <= 16'h0000;
      cmd_write <= 1'b0;
      cmd_byte <= 1'b0;
      width8 <= 1'b0;
      card_ctrl <= 2'h0;
      timing <= `TM_RESET;
      ev <= 4'h0;
      mask <= 4'h0;
      cnt <= 8'h00;
      stschg_q <= 1'b1;
      readdata <= 32'h0000_0000;
      waitrequest <= 1'b1;
      irq <= 1'b0;
      bus.addr <= 11'h000;
      bus.ce_n <= `CE_NONE;
      bus.reg_n <= 1'b1;
      bus.mem_rd_n <= 1'b1;
      bus.mem_wr_n <= 1'b1;
      bus.io_rd_n <= 1'b1;
      bus.io_wr_n <= 1'b1;
      bus.card_reset <= 1'b0;
      bus.host_d_out <= 16'h0000;
      bus.host_d_oe <= 1'b0;
    end else begin
      state <= next_state;
      rgn <= next_rgn;
      host_addr <= next_host_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      cmd_write <= next_cmd_write;
      cmd_byte <= next_cmd_byte;
      width8 <= next_width8;
      card_ctrl <= next_card_ctrl;
      timing <= next_timing;
      ev <= next_ev;
      mask <= next_mask;
      cnt <= next_cnt;
      stschg_q <= next_stschg_q;
      readdata <= next_readdata;
      waitrequest <= next_waitrequest;
      irq <= next_irq;
      bus.addr <= next_addr;
      bus.ce_n <= next_ce_n;
      bus.reg_n <= next_reg_n;
      bus.mem_rd_n <= next_mem_rd_n;
      bus.mem_wr_n <= next_mem_wr_n;
      bus.io_rd_n <= next_io_rd_n;
      bus.io_wr_n <= next_io_wr_n;
      bus.card_reset <= next_card_ctrl[`CC_RESET];
      bus.host_d_out <= next_d_out;
      bus.host_d_oe <= next_d_oe;
    end
  end

endmodule

// ---- rtl/card_peripheral.sv ----
// card end of the bus: sample 16-bit peripheral with memory, attribute and I/O
// assumes strobes come from another domain; user side runs on clock
`timescale 1ns/10ps
`include "card_bus_regs.svh"
module card_peripheral
  import card_bus_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic irq_req,
  input wire logic status_change,
  input wire logic [3:0] wait_len,
  input wire logic io_8bit,
  input wire logic [9:0] user_addr,
  output logic [15:0] user_rdata,
  output logic [15:0] io_value,
  output logic in_reset,
  card_bus_if.card bus
);

  ////////////////////////////////////////////////////////////////////////
  // input conditioning, same filter as the host
  localparam int SW = 35;
  logic [SW-1:0] raw, s1, s2, s3, filt;
  assign raw = {bus.card_reset, bus.reg_n, bus.mem_rd_n, bus.mem_wr_n,
                bus.io_rd_n, bus.io_wr_n, bus.ce_n, bus.addr, bus.d};

  always_ff @(posedge clock) begin
    if (srst) begin
      s1 <= {1'b0, {SW-1{1'b1}}};
      s2 <= {1'b0, {SW-1{1'b1}}};
      s3 <= {1'b0, {SW-1{1'b1}}};
      filt <= {1'b0, {SW-1{1'b1}}};
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      filt <= (s2 & s3) | (filt & (s2 ^ s3));
    end
  end

  logic rst_f, reg_f, mrd_f, mwr_f, iord_f, iowr_f;
  logic [1:0] ce_f;
  logic [10:0] a_f;
  logic [15:0] d_f;
  assign {rst_f, reg_f, mrd_f, mwr_f, iord_f, iowr_f, ce_f, a_f, d_f} = filt;

  ////////////////////////////////////////////////////////////////////////
  // storage and bus response
  logic [15:0] mem [`CARD_WORDS];
  logic [15:0] attr_word, next_attr_word, next_io_value, next_user_rdata;
  logic [3:0] strb_q, next_strb_q;
  logic [`WAIT_W-1:0] wcnt, next_wcnt;
  logic [15:0] next_d_out;
  logic next_d_oe, next_wait_n, mem_we, rd_on, any_fall, wr_end_mem, wr_end_io;
  logic reset_all;
  logic [9:0] widx;

  always_comb begin
    reset_all = srst || rst_f;
    widx = a_f[10:1];
    // attribute space only with region select low
    any_fall = |(strb_q & ~{mrd_f, mwr_f, iord_f, iowr_f});
    wr_end_mem = !strb_q[2] && mwr_f;
    wr_end_io = !strb_q[0] && iowr_f;
    next_strb_q = {mrd_f, mwr_f, iord_f, iowr_f};
    next_attr_word = attr_word;
    next_io_value = io_value;
    mem_we = wr_end_mem && reg_f;
    if (wr_end_mem && !reg_f) next_attr_word = d_f;
    if (wr_end_io) next_io_value = io_8bit ? {8'h00, d_f[7:0]} : d_f;
    next_wcnt = wcnt;
    if (any_fall) next_wcnt = wait_len;
    else if (wcnt != '0) next_wcnt = wcnt - 4'h1;
    next_wait_n = (next_wcnt == '0);
    rd_on = (!mrd_f || !iord_f) && ce_f != `CE_NONE;
    next_d_oe = rd_on;
    if (!iord_f) next_d_out = io_8bit ? {8'h00, io_value[7:0]} : io_value;
    else if (reg_f) next_d_out = mem[widx];
    else next_d_out = attr_word;
    next_user_rdata = mem[user_addr];
  end

  always_ff @(posedge clock) begin
    if (mem_we) mem[widx] <= d_f;
  end

  always_ff @(posedge clock) begin
    if (reset_all) begin
      strb_q <= 4'hf;
      attr_word <= 16'h0000;
      io_value <= 16'h0000;
      wcnt <= '0;
      user_rdata <= 16'h0000;
      in_reset <= 1'b1;
      bus.card_d_out <= 16'h0000;
      bus.card_d_oe <= 1'b0;
      bus.wait_n <= 1'b1;
      bus.io_is16_n <= 1'b0;
      bus.irq_n <= 1'b1;
      bus.stschg_n <= 1'b1;
      bus.cd_n <= 2'b00;
    end else begin
      strb_q <= next_strb_q;
      attr_word <= next_attr_word;
      io_value <= next_io_value;
      wcnt <= next_wcnt;
      user_rdata <= next_user_rdata;
      in_reset <= 1'b0;
      bus.card_d_out <= next_d_out;
      bus.card_d_oe <= next_d_oe;
      bus.wait_n <= next_wait_n;
      bus.io_is16_n <= io_8bit;
      bus.irq_n <= !irq_req;
      bus.stschg_n <= !status_change;
      bus.cd_n <= 2'b00;
    end
  end

endmodule

// ---- test/card_bus_props.sv ----
// checker on the card bus wires between host controller and sample card
// assumes instantiation beside the interface in the bench top, one clock
`timescale 1ns/10ps
module card_bus_props (
  input wire logic clock,
  input wire logic srst,
  input wire logic [10:0] addr,
  input wire logic [1:0] ce_n,
  input wire logic reg_n,
  input wire logic mem_rd_n,
  input wire logic mem_wr_n,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  input wire logic host_d_oe,
  input wire logic card_d_oe,
  input wire logic wait_n,
  input wire logic [1:0] cd_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic [3:0] stb;
  logic any_low;
  assign stb = {mem_rd_n, mem_wr_n, io_rd_n, io_wr_n};
  assign any_low = stb != 4'hf;
  ////////////////////////////////////////////////////////////////////////
  sequence strobe_start;
    $rose(any_low);
  endsequence
  sequence strobe_end;
    $fell(any_low);
  endsequence
  // shortest legal region timing is 4, so at least five strobe cycles
  a_min_strobe: assert property (strobe_start |-> any_low [*5])
    else $error("strobe shorter than five cycles");
  a_strobe_ends: assert property (strobe_start |-> ##[1:600] !any_low)
    else $error("strobe never released");
  a_hold_release: assert property (strobe_end |=> ce_n == 2'b11 && !host_d_oe)
    else $error("enables or data not released after hold");
  a_one_strobe: assert property (any_low |-> $onehot(~stb))
    else $error("more than one strobe low");
  a_enable_set: assert property (any_low |-> ce_n inside {2'b10, 2'b01})
    else $error("no width code on enables during strobe");
  a_addr_steady: assert property (any_low && $past(any_low) |->
    $stable(addr) && $stable(reg_n) && $stable(ce_n))
    else $error("address or region select moved during strobe");
  a_write_drives: assert property (!mem_wr_n || !io_wr_n |-> host_d_oe && !card_d_oe)
    else $error("write data not driven by host alone");
  a_read_quiet: assert property (!mem_rd_n || !io_rd_n |-> !host_d_oe)
    else $error("host drives data during read");
  a_wait_short: assert property ($fell(wait_n) |-> ##[1:40] wait_n)
    else $error("wait held too long");
  a_card_present: assert property (cd_n == 2'b00)
    else $error("card detect lines not low");
endmodule

// ---- test/test_card_bus_external_data_port.sv ----
// self-checking bench joining the host controller and the sample card
// assumes both ends on one clock; card contents kept in an int model
`timescale 1ns/10ps
`include "card_bus_regs.svh"
module test_card_bus_external_data_port;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq;
  logic irq_req = 1'b0;
  logic status_change = 1'b0;
  logic [3:0] wait_len = 4'h0;
  logic io_8bit = 1'b0;
  logic [9:0] user_addr = 10'h000;
  logic [15:0] user_rdata;
  logic [15:0] io_value;
  logic in_reset;
  int err_total = 0;
  int n_compared = 0;
  int mem_model [1024];
  int que_a [$];
  int dur;
  logic [15:0] seed = 16'h0012;
  logic [31:0] rd;
  logic [31:0] bad [3] = '{32'h3000_0800, 32'h3400_0000, 32'h3bff_fffe};
  always #4 clock = ~clock;
  card_bus_if card_bus_if_i();
  card_host card_host_i(.clock(clock), .srst(srst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .bus(card_bus_if_i));
  card_peripheral card_peripheral_i(.clock(clock), .srst(srst), .irq_req(irq_req),
    .status_change(status_change), .wait_len(wait_len), .io_8bit(io_8bit),
    .user_addr(user_addr), .user_rdata(user_rdata), .io_value(io_value),
    .in_reset(in_reset), .bus(card_bus_if_i));
  card_bus_props card_bus_props_i(.clock(clock), .srst(srst), .addr(card_bus_if_i.addr),
    .ce_n(card_bus_if_i.ce_n), .reg_n(card_bus_if_i.reg_n),
    .mem_rd_n(card_bus_if_i.mem_rd_n), .mem_wr_n(card_bus_if_i.mem_wr_n),
    .io_rd_n(card_bus_if_i.io_rd_n), .io_wr_n(card_bus_if_i.io_wr_n),
    .host_d_oe(card_bus_if_i.host_d_oe), .card_d_oe(card_bus_if_i.card_d_oe),
    .wait_n(card_bus_if_i.wait_n), .cd_n(card_bus_if_i.cd_n));
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("errors %0d, comparisons %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  task automatic give_up(input string what);
    $display("MISMATCH %s expected answer seen timeout", what);
    err_total++;
    wrap_up();
  endtask
  // request held until waitrequest is sampled low, released at that edge
  task automatic av(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    int i;
    @(posedge clock);
    address <= a;
    writedata <= wd;
    read <= !wr;
    write <= wr;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (waitrequest === 1'b0) break;
    end
    if (i == 50) give_up("waitrequest");
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // dur counts busy polls, coarse but enough to compare two cycles
  task automatic card_op(input logic [31:0] ha, input logic [15:0] wd, input logic [2:0] cmd);
    int i;
    av(1'b1, `OFS_HOST_ADDR, ha);
    av(1'b1, `OFS_WDATA, {16'h0000, wd});
    av(1'b1, `OFS_CMD, {29'h0, cmd});
    dur = 0;
    for (i = 0; i < 200; i++) begin
      av(1'b0, `OFS_STATUS, 32'h0);
      if (rd[`ST_BUSY] === 1'b0) break;
      dur++;
    end
    if (i == 200) give_up("busy");
    av(1'b0, `OFS_RDATA, 32'h0);
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    int a;
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    repeat (8) @(posedge clock);
    av(1'b0, `OFS_STATUS, 32'h0);
    check("status", 32'h4, rd & 32'hf);
    av(1'b0, `OFS_TIMING, 32'h0);
    check("timing", 32'h080808, rd);
    // read data crosses two three-flop filters: a read needs nine cycles of timing
    av(1'b1, `OFS_TIMING, 32'h0a0909);
    av(1'b0, `OFS_TIMING, 32'h0);
    check("timing set", 32'h0a0909, rd);
    av(1'b0, 6'h24, 32'h0);
    check("unmapped", 32'h0, rd);
    for (i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      a = seed & 16'h07fe;
      seed = lfsr(seed);
      mem_model[a >> 1] = seed;
      que_a.push_back(a);
      card_op(`MEM_BASE + a, seed, 3'b011);
    end
    foreach (que_a[k]) begin
      card_op(`MEM_BASE + que_a[k], 16'h0000, 3'b001);
      check("mem read", mem_model[que_a[k] >> 1], rd);
      user_addr <= 10'(que_a[k] >> 1);
      repeat (3) @(posedge clock);
      check("user word", mem_model[que_a[k] >> 1], {16'h0, user_rdata});
    end
    card_op(`MEM_BASE + 32'h10, 16'hc3a5, 3'b011);
    card_op(`ATTR_BASE + 32'h10, 16'h5a3c, 3'b011);
    card_op(`ATTR_BASE + 32'h7fe, 16'h0, 3'b001);
    check("attr", 32'h5a3c, rd);
    card_op(`MEM_BASE + 32'h10, 16'h0, 3'b001);
    check("mem apart", 32'hc3a5, rd);
    card_op(`MEM_BASE + 32'h10, 16'h0, 3'b101);
    check("byte read", 32'h00a5, rd);
    av(1'b0, `OFS_STATUS, 32'h0);
    check("byte width", 32'h2, rd & 32'h2);
    card_op(`IO_BASE + 32'h2, 16'hbeef, 3'b011);
    check("io value", 32'hbeef, {16'h0, io_value});
    card_op(`IO_BASE + 32'h2, 16'h0, 3'b001);
    check("io word", 32'hbeef, rd);
    io_8bit <= 1'b1;
    card_op(`IO_BASE + 32'h2, 16'h0, 3'b001);
    check("io byte", 32'h00ef, rd);
    av(1'b0, `OFS_STATUS, 32'h0);
    check("width flag", 32'h2, rd & 32'h2);
    io_8bit <= 1'b0;
    foreach (bad[k]) begin
      av(1'b1, `OFS_IRQ_STATUS, 32'hf);
      card_op(bad[k], 16'h0, 3'b011);
      av(1'b0, `OFS_IRQ_STATUS, 32'h0);
      check("window error", 32'h8, rd & 32'h8);
    end
    // a long wait must stretch the cycle unless the control bit masks it
    wait_len <= 4'hf;
    card_op(`MEM_BASE, 16'h1111, 3'b011);
    a = dur;
    av(1'b1, `OFS_CARD_CTRL, 32'h1);
    card_op(`MEM_BASE, 16'h2222, 3'b011);
    check("wait ignored", 32'h1, 32'(dur < a));
    av(1'b1, `OFS_CARD_CTRL, 32'h0);
    card_op(`MEM_BASE, 16'h0, 3'b001);
    check("stretched", 32'h2222, rd);
    wait_len <= 4'h0;
    av(1'b1, `OFS_IRQ_STATUS, 32'hf);
    card_op(`MEM_BASE, 16'h0, 3'b001);
    av(1'b0, `OFS_IRQ_STATUS, 32'h0);
    check("done event", 32'h1, rd);
    irq_req <= 1'b1;
    repeat (8) @(posedge clock);
    av(1'b1, `OFS_IRQ_MASK, 32'h2);
    repeat (3) @(posedge clock);
    check("irq on", 32'h1, {31'h0, irq});
    av(1'b0, `OFS_STATUS, 32'h0);
    check("irq line", 32'h8, rd & 32'h8);
    av(1'b1, `OFS_IRQ_MASK, 32'h0);
    repeat (3) @(posedge clock);
    check("irq masked", 32'h0, {31'h0, irq});
    irq_req <= 1'b0;
    status_change <= 1'b1;
    repeat (8) @(posedge clock);
    av(1'b1, `OFS_IRQ_STATUS, 32'h2);
    av(1'b0, `OFS_IRQ_STATUS, 32'h0);
    check("stschg event", 32'h5, rd);
    status_change <= 1'b0;
    av(1'b1, `OFS_IRQ_STATUS, 32'hf);
    av(1'b0, `OFS_IRQ_STATUS, 32'h0);
    check("events cleared", 32'h0, rd);
    av(1'b1, `OFS_CARD_CTRL, 32'h2);
    repeat (6) @(posedge clock);
    check("card held", 32'h1, {31'h0, in_reset});
    av(1'b1, `OFS_CARD_CTRL, 32'h0);
    repeat (6) @(posedge clock);
    check("card free", 32'h0, {31'h0, in_reset});
    wrap_up();
  end
endmodule
